/* File: test/term_model.sv */
// Purpose: terminal side that drains the tx stream
// Assumes: bytes taken on valid and ready at a rising edge
// Notes: hold stops it so the fifo can fill
`timescale 1ns/1ps
`default_nettype none
module term_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var logic tx_ready
);
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [7:0] got [$];
  integer seed = 32'h13572468;
  initial tx_ready = 1'b0;
  // random stalls, a slow terminal is as legal as a fast one
  always @(posedge clock) begin
    if (rstn && tx_valid && tx_ready) got.push_back(tx_data);
    #1 tx_ready <= !hold && ($random(seed) & 3) != 0;
  end
endmodule // term_model
`default_nettype wire

/* File: test/terminal_call_handshake_checker.sv */
// Purpose: port checks for the terminal call handshake
// Assumes: one clock, rstn async active low
// Notes: drop length allows one prescaler period of slack
`timescale 1ns/1ps
`default_nettype none
`include "call_ctl_defines.vh"
module call_checker #(
  parameter int PRESCALE = 10,
  parameter int DROP_MS = 3,
  parameter int RETRY_MS = 5
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] mode,
  input wire logic config_done,
  input wire logic dtr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_long_break,
  input wire logic local_release,
  input wire logic call_failed,
  input wire logic dsr,
  input wire logic dcd,
  input wire logic cts,
  input wire logic autobaud_active,
  input wire logic dialogue,
  input wire logic connected,
  input wire logic call_request,
  input wire logic call_abandon,
  input wire logic cmd_valid,
  input wire logic data_valid,
  input wire logic [7:0] data_out
);
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  localparam int D_LO = DROP_MS * PRESCALE;
  localparam int D_HI = D_LO + PRESCALE + 1;
  localparam int R_LO = (RETRY_MS - 1) * PRESCALE - 8;
  localparam int R_HI = (RETRY_MS + 1) * PRESCALE;
  logic [31:0] low_n;
  logic armed;
  // armed only after a high phase, so the reset-time low is not measured
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      low_n <= 32'h0;
      armed <= 1'b0;
    end else if (!dsr) begin
      low_n <= low_n + 32'h1;
    end else begin
      low_n <= 32'h0;
      armed <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_drop;
    !dsr && !dcd && !cts;
  endsequence
  sequence s_retry;
    !call_request [*8] ##[R_LO:R_HI] call_request;
  endsequence
  property p_rel; local_release && (dialogue || connected) |=> s_drop; endproperty
  a_rel: assert property (p_rel) else $error("release no drop");
  property p_brk; rx_long_break && (dialogue || connected) |=> s_drop; endproperty
  a_brk: assert property (p_brk) else $error("break no drop");
  property p_tied; dsr == dcd && dcd == cts; endproperty
  a_tied: assert property (p_tied) else $error("lines split");
  property p_len; $rose(dsr) && armed |-> low_n >= D_LO && low_n <= D_HI; endproperty
  a_len: assert property (p_len) else $error("drop length");
  property p_hot;
    mode == `MODE_VLL && $rose(dtr) && dsr && !connected |-> ##[1:8] call_request;
  endproperty
  a_hot: assert property (p_hot) else $error("no hotline");
  property p_retry; call_failed && dtr && mode == `MODE_VLL |=> s_retry; endproperty
  a_retry: assert property (p_retry) else $error("retry timing");
  property p_cfg; !config_done |-> !dialogue && !cmd_valid; endproperty
  a_cfg: assert property (p_cfg) else $error("early dialogue");
  property p_quiet; autobaud_active |-> !cmd_valid && !dialogue; endproperty
  a_quiet: assert property (p_quiet) else $error("autobaud cmd");
  property p_pass;
    connected && rx_valid |=> data_valid && data_out == $past(rx_data);
  endproperty
  a_pass: assert property (p_pass) else $error("not transparent");
  property p_abort;
    dialogue && rx_valid && rx_data == `CHR_CTLZ |-> ##[1:3] call_abandon;
  endproperty
  a_abort: assert property (p_abort) else $error("no abandon");
endmodule // call_checker
bind terminal_call_handshake call_checker #(.PRESCALE(PRESCALE), .DROP_MS(DROP_MS),
  .RETRY_MS(RETRY_MS)) chk (.clock, .rstn, .mode, .config_done, .dtr, .rx_valid,
  .rx_data, .rx_long_break, .local_release, .call_failed, .dsr, .dcd, .cts,
  .autobaud_active, .dialogue, .connected, .call_request, .call_abandon, .cmd_valid,
  .data_valid, .data_out);
`default_nettype wire

/* File: test/terminal_call_handshake_tb_top.sv */
// Purpose: self-checking bench for the call handshake
// Assumes: shortened timers, prescale of 10 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "call_ctl_defines.vh"
module terminal_call_handshake_tb_top;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int PS = 10;
  localparam int LO = 3 * PS;
  logic clock = 1'b0, rstn = 1'b0, config_done = 1'b0, dtr = 1'b0, rx_valid = 1'b0;
  logic rx_long_break = 1'b0, rx_short_break = 1'b0, rate_locked = 1'b0, hold = 1'b0;
  logic local_release = 1'b0, call_answered = 1'b0, call_failed = 1'b0;
  logic prompt_valid = 1'b0, prompt_last = 1'b0, prompt_cp = 1'b0;
  logic [7:0] rx_data = 8'h00, prompt_data = 8'h00, b;
  logic [3:0] mode = `MODE_VLL;
  logic [1:0] prompt_kind = 2'h0;
  logic dce_mode = 1'b1, ring_done = 1'b1;
  logic prompt_ready, dsr, dcd, cts, autobaud_active, dialogue, connected, tx_ready;
  logic call_request, call_abandon, cmd_valid, data_valid, tx_valid;
  logic [7:0] cmd_data, data_out, tx_data;
  integer errors = 0, n_compared = 0, seed = 32'he62752d5, n, i;
  terminal_call_handshake #(.PRESCALE(PS), .DROP_MS(3), .DTR_OFF_MS(2), .RETRY_MS(5)) dut (
    .clock, .rstn, .mode, .dce_mode, .config_done, .ring_done, .dtr,
    .rx_valid, .rx_data, .rx_long_break, .rx_short_break, .rate_locked, .local_release,
    .call_answered, .call_failed, .prompt_valid, .prompt_ready, .prompt_data, .prompt_last,
    .prompt_cp, .prompt_kind, .dsr, .dcd, .cts, .autobaud_active, .dialogue, .connected,
    .call_request, .call_abandon, .cmd_valid, .cmd_data, .data_valid, .data_out,
    .tx_valid, .tx_ready, .tx_data);
  term_model tm (.clock, .rstn, .hold, .tx_valid, .tx_data, .tx_ready);
  always #5 clock = ~clock;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [7:0] up(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wait_v(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic drop_len();
    wait_v(dsr, 1'b0, 60);
    wait_v(dsr, 1'b1, 80);
    chk("drop_len", 1, n >= LO - 2 && n <= LO + PS + 2);
  endtask
  task automatic hot_call();
    dtr = 1'b0;
    tick(2);
    dtr = 1'b1;
    wait_v(call_request, 1'b1, 8);
    chk("hotline", 1, call_request);
  endtask
  task automatic rx(input logic [7:0] d);
    rx_data = d;
    rx_valid = 1'b1;
    tick();
    rx_valid = 1'b0;
  endtask
  task automatic pr(input logic [7:0] d, input logic last);
    prompt_data = d;
    prompt_last = last;
    prompt_valid = 1'b1;
    wait_v(prompt_ready, 1'b1, 50);
    tick();
    prompt_valid = 1'b0;
    tick();
  endtask
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    tick(10);
    rstn = 1'b1;
    tick(2);
    chk("idle", 32'h7, {dsr, dcd, cts});
    config_done = 1'b1;
    hot_call();
    pulse(call_failed);
    wait_v(call_request, 1'b1, 90);
    chk("retry", 1, n >= 4 * PS - 2 && n <= 6 * PS);
    pulse(call_answered);
    chk("connected", 1, connected);
    for (i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      rx(b);
      chk("data_out", {23'h0, 1'b1, b}, {23'h0, data_valid, data_out});
      chk("no_echo", 0, tx_valid);
      tick();
    end
    pulse(local_release);
    drop_len();
    hot_call();
    pulse(call_answered);
    pulse(rx_long_break);
    drop_len();
    hot_call();
    pulse(call_answered);
    dtr = 1'b0;
    tick(PS);
    dtr = 1'b1;
    tick(3 * PS);
    chk("short_dtr", 1, dsr);
    dtr = 1'b0;
    drop_len();
    hot_call();
    pulse(call_answered);
    repeat (3) pulse(rx_short_break);
    drop_len();
    mode = `MODE_TERM;
    rate_locked = 1'b1;
    wait_v(autobaud_active, 1'b1, 4);
    rx(8'h41);
    tick();
    chk("autobaud_hold", 32'h4, {autobaud_active, dialogue, tx_valid});
    rx(`CHR_CR);
    wait_v(dialogue, 1'b1, 20);
    chk("dialogue", 1, dialogue);
    hold = 1'b1;
    prompt_cp = 1'b1;
    prompt_kind = 2'h1;
    for (i = 0; i < 6; i++) pr(8'h61 + 8'(i), i == 5);
    tick(5);
    chk("fifo_full", 0, prompt_ready);
    hold = 1'b0;
    tick(60);
    chk("prompt_len", 9, tm.got.size());
    chk("cr", `CHR_CR, tm.got[0]);
    chk("lf", `CHR_LF, tm.got[1]);
    for (i = 0; i < 6; i++) chk("text", up(8'h61 + 8'(i)), tm.got[i + 2]);
    chk("colon", `CHR_COLON, tm.got[8]);
    rx(8'h78);
    wait_v(cmd_valid, 1'b1, 3);
    chk("cmd", 8'h78, cmd_data);
    tick(5);
    chk("host_echo", 9, tm.got.size());
    mode = 4'h1;
    rx(8'h79);
    tick(20);
    chk("echo_len", 10, tm.got.size());
    chk("echo", 8'h79, tm.got[9]);
    rx(`CHR_CTLZ);
    wait_v(call_abandon, 1'b1, 3);
    chk("abandon", 1, call_abandon);
    tick(3);
    chk("autobaud", 1, autobaud_active);
    dce_mode = 1'b0;
    ring_done = 1'b0;
    tick(2);
    chk("no_ring", 0, autobaud_active);
    ring_done = 1'b1;
    tick(2);
    chk("ring", 1, autobaud_active);
    end_of_test();
  end
endmodule // terminal_call_handshake_tb_top
`default_nettype wire

/* File: verilog/byte_fifo.v */
// Purpose: small synchronous fifo for the echo/prompt path
// Assumes: single clock
// Notes: depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always @(posedge clock) begin
    if (in_valid && !full)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // byte_fifo
`default_nettype wire

/* File: verilog/call_ctl_defines.vh */
// Purpose: constants for the terminal call handshake block
// Assumes: 100 MHz core clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef CALL_CTL_DEFINES_VH
`define CALL_CTL_DEFINES_VH
`define CLK_HZ 100000000
`define DROP_MS 200
`define DTR_OFF_MS 100
`define RETRY_S 40
`define MS_TICKS (`CLK_HZ / 1000)
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
`define CHR_CTLZ 8'h1a
`define CHR_COLON 8'h3a
`define CHR_QMARK 8'h3f
`define MODE_TERM 4'hc
`define MODE_HOTLINE 4'hd
`define MODE_FORCED 4'he
`define MODE_VLL 4'hf
`define BAUD_MIN 110
`define BAUD_MAX 19200
`define SHORT_BREAKS 2'h3
`endif

/* File: verilog/terminal_call_handshake.v */
// Purpose: terminal-facing call control for a data port adapter
// Assumes: rx bytes/breaks arrive decoded, synchronous to clock
// Notes: prompt text supplied by call processing as a byte stream
//
// Overview of operation
// R1: local data_module release drops dsr, dcd, cts for 0.2 s then restores.
// R2: long break or three short breaks cause the same 0.2 s drop.
// R3: in virtual leased line mode dtr assertion starts a hotline call.
// R4: busy or unanswered hotline call retried every 40 s while dtr holds.
// R5: virtual leased line teardown identical to terminal access mode.
// R6: dtr low for at least 100 ms is a disconnect with 0.2 s drop.
// R7: autobaud covers 110 to 19200 bits per second.
// R8: during rate detection only carriage return counts, nothing echoed.
// R9: commands ignored until configuration download has completed.
// R10: as dce, terminal asserts dtr first unless forced dtr mode.
// R11: as dte, ring indicator cycles configured times before dialogue.
// R12: dialogue phase echoes every received user character.
// R13: connected call passes data transparently, no local echo.
// R14: host modes 12 to 15 suppress dialogue echo.
// R15: call processing prompts are forced to upper case.
// R16: every prompt preceded by carriage return and line feed.
// R17: input prompts end with a colon.
// R18: yes/no prompts end with question mark and reply list.
// R19: control-z in dialogue abandons the call setup at once.
// R20: drop and retry intervals timed from a prescaled core clock.
`timescale 1ns/1ps
`default_nettype none
`include "call_ctl_defines.vh"
module terminal_call_handshake #(
  parameter PRESCALE = `MS_TICKS,
  parameter DROP_MS = `DROP_MS,
  parameter DTR_OFF_MS = `DTR_OFF_MS,
  parameter RETRY_MS = `RETRY_S * 1000,
  parameter FIFO_DEPTH = 8
) (
  input wire clock,
  input wire rstn,
  input wire [3:0] mode,
  input wire dce_mode,
  input wire config_done,
  input wire ring_done,
  input wire dtr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_long_break,
  input wire rx_short_break,
  input wire rate_locked,
  input wire local_release,
  input wire call_answered,
  input wire call_failed,
  input wire prompt_valid,
  output wire prompt_ready,
  input wire [7:0] prompt_data,
  input wire prompt_last,
  input wire prompt_cp,
  input wire [1:0] prompt_kind,
  output reg dsr,
  output reg dcd,
  output reg cts,
  output reg autobaud_active,
  output reg dialogue,
  output reg connected,
  output reg call_request,
  output reg call_abandon,
  output reg cmd_valid,
  output reg [7:0] cmd_data,
  output reg data_valid,
  output reg [7:0] data_out,
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_BAUD = 3'h1;
  localparam ST_DIAL = 3'h2;
  localparam ST_CALL = 3'h3;
  localparam ST_CONN = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam ST_DROP = 3'h6;
  localparam PK_PLAIN = 2'h0;
  localparam PK_INPUT = 2'h1;
  localparam PK_YESNO = 2'h2;
  reg [2:0] state;
  reg [2:0] next_state;
  // ----------------------------------------
  // millisecond prescaler
  // ----------------------------------------
  reg [31:0] pre_cnt;
  wire ms_tick = (pre_cnt == PRESCALE - 1); // see R20
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      pre_cnt <= 32'h0;
    else if (ms_tick)
      pre_cnt <= 32'h0;
    else
      pre_cnt <= pre_cnt + 32'h1;
  end
  // ----------------------------------------
  // qualifiers
  // ----------------------------------------
  wire vll = (mode == `MODE_VLL);
  wire host = (mode >= `MODE_TERM); // see R14
  wire dtr_eff = dtr || (mode == `MODE_FORCED) || !dce_mode;
  wire ready_eff = config_done && (dce_mode ? dtr_eff : ring_done); // see R9
  reg [15:0] dtr_off_ms;
  reg [1:0] short_cnt;
  reg dtr_q;
  wire dtr_rise = dtr && !dtr_q;
  wire dtr_disc = ms_tick && !dtr_eff && (dtr_off_ms == DTR_OFF_MS - 1); // see R6
  wire brk_disc = rx_long_break || (rx_short_break && short_cnt == `SHORT_BREAKS - 2'h1);
  wire in_call = (state == ST_DIAL) || (state == ST_CALL) || (state == ST_CONN)
    || (state == ST_WAIT);
  // local release, breaks and dtr loss share one teardown for every mode
  wire disc = in_call && (local_release || brk_disc || dtr_disc); // see R1 see R2 see R5
  wire is_ctlz = rx_valid && rx_data == `CHR_CTLZ;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dtr_q <= 1'b0;
      dtr_off_ms <= 16'h0;
      short_cnt <= 2'h0;
    end else begin
      dtr_q <= dtr;
      if (dtr_eff)
        dtr_off_ms <= 16'h0;
      else if (ms_tick && dtr_off_ms != DTR_OFF_MS)
        dtr_off_ms <= dtr_off_ms + 16'h1;
      if (disc || !in_call)
        short_cnt <= 2'h0;
      else if (rx_short_break) // see R2
        short_cnt <= short_cnt + 2'h1;
    end
  end
  // ----------------------------------------
  // interval timer: drop and retry
  // ----------------------------------------
  reg [31:0] tmr;
  // one extra tick: the first tick may come early, the drop must never fall short
  wire drop_end = (state == ST_DROP) && ms_tick && (tmr == DROP_MS); // see R1
  wire retry_end = (state == ST_WAIT) && ms_tick && (tmr == RETRY_MS - 1); // see R4
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      tmr <= 32'h0;
    else if (state != next_state)
      tmr <= 32'h0;
    else if (ms_tick)
      tmr <= tmr + 32'h1;
  end
  // ----------------------------------------
  // call state machine
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (vll && dtr_rise && config_done)
          next_state = ST_CALL; // see R3
        else if (!vll && ready_eff)
          next_state = ST_BAUD;
      end
      ST_BAUD: begin
        // autobaud engine locks 110..19200 on the cr, see R7
        if (!ready_eff)
          next_state = ST_IDLE;
        else if (rx_valid && rx_data == `CHR_CR && rate_locked)
          next_state = ST_DIAL; // see R8
      end
      ST_DIAL: begin
        if (is_ctlz)
          next_state = ST_BAUD; // see R19
        else if (call_answered)
          next_state = ST_CONN;
      end
      ST_CALL: begin
        if (call_answered)
          next_state = ST_CONN;
        else if (call_failed)
          next_state = vll ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (!dtr)
          next_state = ST_IDLE; // see R4
        else if (retry_end)
          next_state = ST_CALL;
      end
      ST_CONN: next_state = ST_CONN;
      ST_DROP: begin
        if (drop_end)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (disc)
      next_state = ST_DROP;
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end
  // ----------------------------------------
  // control lines and status
  // ----------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dsr <= 1'b0;
      dcd <= 1'b0;
      cts <= 1'b0;
      autobaud_active <= 1'b0;
      dialogue <= 1'b0;
      connected <= 1'b0;
      call_request <= 1'b0;
      call_abandon <= 1'b0;
    end else begin
      dsr <= next_state != ST_DROP; // see R1 see R2 see R6
      dcd <= next_state != ST_DROP;
      cts <= next_state != ST_DROP;
      autobaud_active <= next_state == ST_BAUD;
      dialogue <= next_state == ST_DIAL;
      connected <= next_state == ST_CONN;
      call_request <= (next_state == ST_CALL) && (state != ST_CALL); // see R3 see R4
      call_abandon <= (state == ST_DIAL) && is_ctlz; // see R19
    end
  end
  // ----------------------------------------
  // receive path: commands, data, echo
  // ----------------------------------------
  wire dial_rx = (state == ST_DIAL) && rx_valid && !is_ctlz;
  wire want_echo = dial_rx && !host; // see R12 see R14
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_data <= 8'h0;
      data_valid <= 1'b0;
      data_out <= 8'h0;
    end else begin
      cmd_valid <= dial_rx && config_done; // see R9
      data_valid <= (state == ST_CONN) && rx_valid; // see R13
      if (rx_valid) begin
        cmd_data <= rx_data;
        data_out <= rx_data;
      end
    end
  end
  // ----------------------------------------
  // prompt framing into the tx fifo
  // ----------------------------------------
  reg [1:0] pf_phase; // 0 text, 1 lf pending, 2 unused, 3 tail
  reg pf_open;
  reg [1:0] tail_cnt;
  reg [7:0] fin;
  reg fin_valid;
  wire fin_ready;
  wire [7:0] up = (prompt_cp && prompt_data >= 8'h61 && prompt_data <= 8'h7a)
    ? prompt_data - 8'h20 : prompt_data; // see R15
  // echo has priority; prompts wait a cycle when a char arrives
  assign prompt_ready = pf_open && pf_phase == 2'h0 && !want_echo && fin_ready;
  always @* begin
    fin_valid = 1'b0;
    fin = rx_data;
    if (want_echo) begin
      fin_valid = 1'b1;
    end else if (prompt_valid && !pf_open) begin
      fin_valid = 1'b1;
      fin = `CHR_CR; // see R16
    end else if (pf_open && pf_phase == 2'h1) begin
      fin_valid = 1'b1;
      fin = `CHR_LF; // see R16
    end else if (pf_open && pf_phase == 2'h0 && prompt_valid) begin
      fin_valid = 1'b1;
      fin = up;
    end else if (pf_open && pf_phase == 2'h3) begin
      fin_valid = 1'b1;
      fin = (prompt_kind == PK_INPUT) ? `CHR_COLON : `CHR_QMARK; // see R17 see R18
    end
  end
  // yes/no: question mark inserted, then the reply list text follows
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pf_open <= 1'b0;
      pf_phase <= 2'h0;
      tail_cnt <= 2'h0;
    end else if (!want_echo && fin_ready) begin
      if (prompt_valid && !pf_open) begin
        pf_open <= 1'b1;
        pf_phase <= 2'h1;
      end else if (pf_open && pf_phase == 2'h1) begin
        pf_phase <= 2'h0;
      end else if (pf_open && pf_phase == 2'h0 && prompt_valid) begin
        // reply list segment closes the yes/no prompt without a second mark
        if (prompt_last && prompt_kind != PK_PLAIN && tail_cnt == 2'h0)
          pf_phase <= 2'h3;
        else if (prompt_last) begin
          pf_open <= 1'b0;
          tail_cnt <= 2'h0;
        end
      end else if (pf_open && pf_phase == 2'h3) begin
        if (prompt_kind == PK_YESNO && tail_cnt == 2'h0) begin
          tail_cnt <= 2'h1;
          pf_phase <= 2'h0;
        end else begin
          tail_cnt <= 2'h0;
          pf_open <= 1'b0;
          pf_phase <= 2'h0;
        end
      end
    end
  end
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_tx_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .in_data(fin),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule // terminal_call_handshake
`default_nettype wire
